/* File: hw/pot_pkg.sv */
// Purpose: shared constants and types of the two-wire pot slave
// Assumes: system clock 125 MHz, link sampling clock period 30 ns
// Notes: every timing count is derived from its printed time
package pot_pkg;

  // ==========================================================
  // clocks and timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int LINK_PERIOD_PS = 30000;
  localparam int INPUT_GLITCH_FILTER_TIME_NS = 200;
  // least time: round up to whole link cycles
  localparam int GLITCH_CYCLES =
    (INPUT_GLITCH_FILTER_TIME_NS * 1000 + LINK_PERIOD_PS - 1) /
    LINK_PERIOD_PS;
  localparam int NV_PROGRAM_TIME_MS = 5;
  // longest time: round down
  localparam int NV_PROGRAM_CYCLES =
    NV_PROGRAM_TIME_MS * 1000 * SYS_CLK_MHZ;

  // ==========================================================
  // byte layouts
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int DEV_MSB = 3;
  localparam int DEV_LSB = 0;
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int REG_SEL_MSB = 3;
  localparam int REG_SEL_LSB = 2;
  localparam int POT_SEL_MSB = 1;
  localparam int POT_SEL_LSB = 0;
  // arbitrary device-type code, not a real part's value
  localparam logic [3:0] DEV_TYPE_CODE = 4'h9;

  // ==========================================================
  // opcodes
  localparam logic [3:0] OPC_RD_WIPER = 4'h9;
  localparam logic [3:0] OPC_WR_WIPER = 4'ha;
  localparam logic [3:0] OPC_RD_DATA = 4'hb;
  localparam logic [3:0] OPC_WR_DATA = 4'hc;
  localparam logic [3:0] OPC_WIPER_TO_DATA = 4'he;

  // ==========================================================
  // link state machine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_WAIT_STOP
  } link_state_t;

endpackage

/* File: hw/in_filter.sv */
// Purpose: pin synchroniser and glitch suppressor for one input
// Assumes: runs on the link sampling clock
// Notes: output follows the pin only after it held STABLE samples
`timescale 1ns/1ps
module in_filter #(
  parameter int STABLE = 7
) (
  input wire logic clk_link,
  input wire logic rst_link_n,
  input wire logic pin_in,
  output logic filt
);
  localparam int W = $clog2(STABLE + 1);
  logic s1_r;
  logic s2_r;
  logic filt_r;
  logic [W-1:0] cnt_r;

  // idle bus reads high
  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      filt_r <= 1'b1;
      cnt_r <= '0;
    end else if (s2_r == filt_r) begin
      cnt_r <= '0;
    end else if (cnt_r == W'(STABLE - 1)) begin
      filt_r <= s2_r;
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign filt = filt_r;
endmodule

/* File: hw/delay_timer.sv */
// Purpose: one-shot busy window of COUNT - 1 system cycles
// Assumes: start is a single-cycle pulse on clk_sys
// Notes: a start while busy restarts the window
`timescale 1ns/1ps
module delay_timer #(
  parameter int unsigned COUNT = 625000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= W'(COUNT - 1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);
endmodule

/* File: hw/pot_serial_slave.sv */
// Purpose: two-wire serial slave front end of a quad digital pot
// Assumes: clk_link free running, far faster than the serial clock
// Notes: bytes cross to clk_sys by toggles with held data words
`timescale 1ns/1ps

// Functional notes
// - data stable while clock high; else condition
// - start is data falling, clock high
// - stop is data rising, clock high
// - low address bits must equal straps
// - acknowledge only a full address match
// - receiver holds data low on ninth clock
// - acknowledge every written byte
// - read: eight bits out, sample acknowledge
// - no master acknowledge: release, wait stop
// - programming window after stop: stay silent
// - wiper update within settle time
// - wipers restored soon after supply stable
// - suppress input glitches up to limit
// - instruction: opcode, register, pot select
// - address not acknowledged while programming
module pot_serial_slave
  import pot_pkg::*;
#(
  parameter int unsigned NV_CYCLES = NV_PROGRAM_CYCLES,
  parameter int FILTER_CYCLES = GLITCH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit3,
  output logic [7:0] instr,
  output logic [1:0] reg_sel,
  output logic [1:0] pot_sel,
  output logic instr_valid,
  output logic [7:0] wdata,
  output logic wdata_valid,
  input wire logic [7:0] rd_data,
  output logic nv_busy,
  output logic wiper_restore
);

  // ==========================================================
  // link domain reset and pin conditioning
  logic rst_s1_r;
  logic rst_link_n;
  logic [1:0] pin_raw;
  logic [1:0] pin_f;
  logic scl_f;
  logic sda_f;
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;

  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_link_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_link_n <= rst_s1_r;
    end
  end

  assign pin_raw = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      in_filter #(
        .STABLE(FILTER_CYCLES)
      ) u_filt (
        .clk_link(clk_link),
        .rst_link_n(rst_link_n),
        .pin_in(pin_raw[gi]),
        .filt(pin_f[gi])
      );
    end
  endgenerate

  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];

  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
      strap_s1_r <= {addr_strap_bit3, addr_strap_bit2,
                     addr_strap_bit1, addr_strap_bit0};
      strap_s2_r <= strap_s1_r;
    end
  end

  // ==========================================================
  // bus conditions
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  // data edge with clock high is a condition
  assign start_det = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_det = scl_f & scl_q_r & ~sda_q_r & sda_f;

  // ==========================================================
  // link state machine
  link_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_idx_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] rx_byte_r;
  logic rx_is_data_r;
  logic rx_tgl_r;
  logic rd_req_tgl_r;
  logic stop_tgl_r;
  logic read_mode_r;
  logic wrote_r;
  logic master_ack_r;
  logic sda_oe_n_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic [2:0] rd_ack_s_r;
  logic [7:0] rd_byte_r;
  logic [7:0] rd_hold_r;
  logic rd_ack_tgl_r;
  logic nv_busy_r;
  logic addr_hit;
  logic is_read;

  // straps compared; no match while busy
  assign addr_hit = (shift_r[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE) &&
                    (shift_r[DEV_MSB:DEV_LSB] == strap_s2_r) &&
                    !busy_s2_r;
  assign is_read = (shift_r[OPC_MSB:OPC_LSB] == OPC_RD_WIPER) ||
                   (shift_r[OPC_MSB:OPC_LSB] == OPC_RD_DATA);

  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_is_data_r <= 1'b0;
      rx_tgl_r <= 1'b0;
      rd_req_tgl_r <= 1'b0;
      stop_tgl_r <= 1'b0;
      read_mode_r <= 1'b0;
      wrote_r <= 1'b0;
      master_ack_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (start_det) begin
      state_r <= ST_RX;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      read_mode_r <= 1'b0;
      wrote_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
      wrote_r <= 1'b0;
      if (wrote_r) begin
        stop_tgl_r <= ~stop_tgl_r;
      end
    end else begin
      unique case (state_r)
        ST_IDLE, ST_WAIT_STOP: begin
          sda_oe_n_r <= 1'b1;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BYTE_BITS) begin
            bit_cnt_r <= 4'h0;
            if (byte_idx_r == 2'h0 && !addr_hit) begin
              state_r <= ST_WAIT_STOP;
            end else begin
              sda_oe_n_r <= 1'b0;
              state_r <= ST_RX_ACK;
              if (byte_idx_r != 2'h0) begin
                rx_byte_r <= shift_r;
                rx_is_data_r <= (byte_idx_r != 2'h1);
                rx_tgl_r <= ~rx_tgl_r;
              end
              if (byte_idx_r == 2'h1 && is_read) begin
                read_mode_r <= 1'b1;
                rd_req_tgl_r <= ~rd_req_tgl_r;
              end
              if (byte_idx_r == 2'h2) begin
                wrote_r <= 1'b1;
              end
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            if (byte_idx_r != 2'h2) begin
              byte_idx_r <= byte_idx_r + 2'h1;
            end
            if (read_mode_r) begin
              tx_r <= rd_byte_r;
              sda_oe_n_r <= rd_byte_r[7];
              state_r <= ST_TX;
            end else begin
              sda_oe_n_r <= 1'b1;
              state_r <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == BYTE_BITS - 4'h1) begin
              sda_oe_n_r <= 1'b1;
              bit_cnt_r <= 4'h0;
              rd_req_tgl_r <= ~rd_req_tgl_r;
              state_r <= ST_TX_ACK;
            end else begin
              sda_oe_n_r <= tx_r[6];
              tx_r <= {tx_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            master_ack_r <= ~sda_f;
          end else if (scl_fall) begin
            if (master_ack_r) begin
              tx_r <= rd_byte_r;
              sda_oe_n_r <= rd_byte_r[7];
              state_r <= ST_TX;
            end else begin
              state_r <= ST_WAIT_STOP;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // crossings into the link domain
  // busy level held through two flops
  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      rd_ack_s_r <= 3'h0;
      rd_byte_r <= 8'hff;
    end else begin
      busy_s1_r <= nv_busy_r;
      busy_s2_r <= busy_s1_r;
      rd_ack_s_r <= {rd_ack_s_r[1:0], rd_ack_tgl_r};
      // rd_hold_r is frozen until the next request, so safe to take
      if (rd_ack_s_r[2] ^ rd_ack_s_r[1]) begin
        rd_byte_r <= rd_hold_r;
      end
    end
  end

  // ==========================================================
  // system domain side
  logic [2:0] rx_s_r;
  logic [2:0] rd_s_r;
  logic [2:0] stop_s_r;
  logic rd_pend_r;
  logic [7:0] instr_r;
  logic instr_valid_r;
  logic [7:0] wdata_r;
  logic wdata_valid_r;
  logic restore_r;
  logic restore_done_r;
  logic nv_start;
  logic timer_busy;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_s_r <= 3'h0;
      rd_s_r <= 3'h0;
      stop_s_r <= 3'h0;
    end else begin
      rx_s_r <= {rx_s_r[1:0], rx_tgl_r};
      rd_s_r <= {rd_s_r[1:0], rd_req_tgl_r};
      stop_s_r <= {stop_s_r[1:0], stop_tgl_r};
    end
  end

  // received bytes go out within a few cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_r <= 8'h00;
      instr_valid_r <= 1'b0;
      wdata_r <= 8'h00;
      wdata_valid_r <= 1'b0;
    end else begin
      instr_valid_r <= 1'b0;
      wdata_valid_r <= 1'b0;
      if (rx_s_r[2] ^ rx_s_r[1]) begin
        if (rx_is_data_r) begin
          wdata_r <= rx_byte_r;
          wdata_valid_r <= 1'b1;
        end else begin
          instr_r <= rx_byte_r;
          instr_valid_r <= 1'b1;
        end
      end
    end
  end

  // one cycle of slack lets rd_data follow a fresh instruction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_r <= 1'b0;
      rd_hold_r <= 8'hff;
      rd_ack_tgl_r <= 1'b0;
    end else if (rd_pend_r) begin
      rd_pend_r <= 1'b0;
      rd_hold_r <= rd_data;
      rd_ack_tgl_r <= ~rd_ack_tgl_r;
    end else if (rd_s_r[2] ^ rd_s_r[1]) begin
      rd_pend_r <= 1'b1;
    end
  end

  // non-volatile write starts the window at stop
  assign nv_start = (stop_s_r[2] ^ stop_s_r[1]) &&
                    ((instr_r[OPC_MSB:OPC_LSB] == OPC_WR_DATA) ||
                     (instr_r[OPC_MSB:OPC_LSB] == OPC_WIPER_TO_DATA));

  delay_timer #(
    .COUNT(NV_CYCLES)
  ) u_nv_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(nv_start),
    .busy(timer_busy)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nv_busy_r <= 1'b0;
      restore_r <= 1'b0;
      restore_done_r <= 1'b0;
    end else begin
      nv_busy_r <= timer_busy;
      restore_r <= ~restore_done_r;
      restore_done_r <= 1'b1;
    end
  end

  // ==========================================================
  // outputs
  // open drain: the low level is the only one ever driven
  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign instr = instr_r;
  assign reg_sel = instr_r[REG_SEL_MSB:REG_SEL_LSB];
  assign pot_sel = instr_r[POT_SEL_MSB:POT_SEL_LSB];
  assign instr_valid = instr_valid_r;
  assign wdata = wdata_r;
  assign wdata_valid = wdata_valid_r;
  assign nv_busy = nv_busy_r;
  assign wiper_restore = restore_r;
endmodule

/* File: dv/pot_serial_slave_properties.sv */
// Purpose: port checker of the two-wire pot slave
// Assumes: rst_n clears both clock domains
// Notes: bound to every pot_serial_slave instance
`timescale 1ns/1ps
module pot_slave_props #(
  parameter int unsigned NV_CYCLES = 50
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [7:0] instr,
  input wire logic [1:0] reg_sel,
  input wire logic [1:0] pot_sel,
  input wire logic instr_valid,
  input wire logic [7:0] wdata,
  input wire logic wdata_valid,
  input wire logic nv_busy,
  input wire logic wiper_restore
);
  // ==========================================================
  // helper: length of the busy window so far
  int unsigned busy_cnt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= nv_busy ? busy_cnt_r + 1 : 0;
    end
  end
  // ==========================================================
  // link side
  property p_drain_low;
    @(posedge clk_link) disable iff (!rst_n) sda_out == 1'b0;
  endproperty
  a_drain_low: assert property (p_drain_low)
    else $error("sda_out not low");
  property p_oe_scl_low;
    @(posedge clk_link) disable iff (!rst_n)
      $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("sda_oe_n moved while scl high");
  property p_low_holds;
    @(posedge clk_link) disable iff (!rst_n)
      $rose(scl_in) && !sda_oe_n |=> !sda_oe_n [*8];
  endproperty
  a_low_holds: assert property (p_low_holds)
    else $error("driven low dropped during scl high");
  // ==========================================================
  // user side
  property p_restore_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      wiper_restore |=> !wiper_restore;
  endproperty
  a_restore_pulse: assert property (p_restore_pulse)
    else $error("wiper_restore longer than one cycle");
  property p_ivalid_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      instr_valid |=> !instr_valid;
  endproperty
  a_ivalid_pulse: assert property (p_ivalid_pulse)
    else $error("instr_valid longer than one cycle");
  property p_instr_chg;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(instr) |-> instr_valid;
  endproperty
  a_instr_chg: assert property (p_instr_chg)
    else $error("instr changed without instr_valid");
  property p_wdata_chg;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(wdata) |-> wdata_valid;
  endproperty
  a_wdata_chg: assert property (p_wdata_chg)
    else $error("wdata changed without wdata_valid");
  property p_sel_slice;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_sel == instr[3:2] && pot_sel == instr[1:0];
  endproperty
  a_sel_slice: assert property (p_sel_slice)
    else $error("reg_sel or pot_sel not from instr");
  property p_busy_max;
    @(posedge clk_sys) disable iff (!rst_n) busy_cnt_r <= NV_CYCLES;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("programming window too long");
  c_ack: cover property (@(posedge clk_link) $fell(sda_oe_n));
  c_busy: cover property (@(posedge clk_sys) $rose(nv_busy));
  c_wdata: cover property (@(posedge clk_sys) wdata_valid);
endmodule

bind pot_serial_slave pot_slave_props #(.NV_CYCLES(NV_CYCLES)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .instr(instr), .reg_sel(reg_sel), .pot_sel(pot_sel),
  .instr_valid(instr_valid), .wdata(wdata),
  .wdata_valid(wdata_valid), .nv_busy(nv_busy),
  .wiper_restore(wiper_restore)
);

/* File: dv/bus_master_model.sv */
// Purpose: two-wire bus master driving the slave's pins
// Assumes: sda_w is the resolved wire with its pull-up
// Notes: scl stands high between frames; sda_m 1 = released
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk_sys,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  // quarter of the serial clock; slow so the filters settle
  localparam int Q = 50;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tq(input int n);
    repeat (n * Q) @(posedge clk_sys);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    tq(1);
    scl <= 1'b1;
    tq(1);
    sda_m <= 1'b0;
    tq(1);
    scl <= 1'b0;
    tq(1);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    tq(1);
    scl <= 1'b1;
    tq(1);
    sda_m <= 1'b1;
    tq(2);
  endtask
  // data set while scl low, master clocks
  task automatic clk_bit(input logic v, output logic s);
    sda_m <= v;
    tq(1);
    scl <= 1'b1;
    tq(1);
    s = sda_w;
    tq(1);
    scl <= 1'b0;
    tq(1);
  endtask
  // msb first, ninth bit is acknowledge
  task automatic xfer(input logic [7:0] d, input logic ma,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(ma, a);
  endtask
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of the two-wire pot slave
// Assumes: link clock 30 ns, unrelated to clk_sys
// Notes: short filter and programming window for run time
`timescale 1ns/1ps
module tb_top;
  import pot_pkg::*;
  localparam int NVC = 3000;
  logic clk_sys, clk_link, rst_n, scl, sda_m, sda_w, sda_out, sda_oe_n;
  logic instr_valid, wdata_valid, nv_busy, wiper_restore;
  logic [3:0] strap;
  logic [7:0] instr, wdata, rd_data, rd_val, got_i, got_w, q;
  logic [1:0] reg_sel, pot_sel;
  logic a;
  int n_i = 0;
  int n_rs = 0;
  int err_count, n_compared;
  // pull-up wire: low when either party pulls
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #15 clk_link = ~clk_link;
  end
  bus_master_model u_m (.clk_sys(clk_sys), .sda_w(sda_w),
    .scl(scl), .sda_m(sda_m));
  pot_serial_slave #(.NV_CYCLES(NVC), .FILTER_CYCLES(2)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .addr_strap_bit3(strap[3]), .instr(instr), .reg_sel(reg_sel),
    .pot_sel(pot_sel), .instr_valid(instr_valid), .wdata(wdata),
    .wdata_valid(wdata_valid), .rd_data(rd_data), .nv_busy(nv_busy),
    .wiper_restore(wiper_restore));
  // ==========================================================
  // capture of user-side pulses
  always @(posedge clk_sys) begin
    rd_data <= rd_val;
    if (instr_valid === 1'b1) begin
      got_i <= instr;
      n_i <= n_i + 1;
    end
    if (wdata_valid === 1'b1) begin
      got_w <= wdata;
    end
    if (wiper_restore === 1'b1) begin
      n_rs <= n_rs + 1;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, s);
    n_compared++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic ea);
    u_m.xfer(d, 1'b1, q, a);
    chk("ack", {7'h0, ~ea}, {7'h0, a});
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_write();
    u_m.start();
    wr({DEV_TYPE_CODE, 4'ha}, 1'b1);
    wr({OPC_WR_WIPER, 4'h3}, 1'b1);
    wr(8'h5c, 1'b1);
    u_m.stop();
    chk("instr", {OPC_WR_WIPER, 4'h3}, got_i);
    chk("pot_sel", 8'h03, {6'h0, pot_sel});
    chk("wdata", 8'h5c, got_w);
    chk("nv_busy", 8'h00, {7'h0, nv_busy});
    $display("test write done");
  endtask
  task automatic t_miss();
    int n0;
    n0 = n_i;
    u_m.start();
    wr({DEV_TYPE_CODE, 4'h5}, 1'b0);
    wr({OPC_WR_WIPER, 4'h0}, 1'b0);
    u_m.stop();
    u_m.start();
    wr({~DEV_TYPE_CODE, 4'ha}, 1'b0);
    u_m.stop();
    wr({DEV_TYPE_CODE, 4'ha}, 1'b0);
    u_m.stop();
    chk("n_instr", 8'h00, 8'(n_i - n0));
    $display("test mismatch done");
  endtask
  task automatic t_nv();
    int i;
    u_m.start();
    wr({DEV_TYPE_CODE, 4'ha}, 1'b1);
    wr({OPC_WR_DATA, 4'h6}, 1'b1);
    wr(8'h81, 1'b1);
    u_m.stop();
    chk("nv_busy", 8'h01, {7'h0, nv_busy});
    chk("reg_sel", 8'h01, {6'h0, reg_sel});
    chk("pot_sel", 8'h02, {6'h0, pot_sel});
    u_m.start();
    wr({DEV_TYPE_CODE, 4'ha}, 1'b0);
    u_m.stop();
    for (i = 0; i < 5000 && nv_busy !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    if (nv_busy !== 1'b0) begin
      err_count++;
      end_sim();
    end
    u_m.start();
    wr({DEV_TYPE_CODE, 4'ha}, 1'b1);
    u_m.stop();
    $display("test programming window done");
  endtask
  task automatic t_read();
    strap <= 4'h6;
    rd_val <= 8'ha5;
    u_m.start();
    wr({DEV_TYPE_CODE, 4'h6}, 1'b1);
    wr({OPC_RD_DATA, 4'h9}, 1'b1);
    rd_val <= 8'h3c;
    u_m.xfer(8'hff, 1'b0, q, a);
    chk("rd0", 8'ha5, q);
    u_m.xfer(8'hff, 1'b1, q, a);
    chk("rd1", 8'h3c, q);
    u_m.xfer(8'hff, 1'b1, q, a);
    chk("rd2", 8'hff, q);
    u_m.stop();
    $display("test read done");
  endtask
  task automatic t_restart();
    u_m.start();
    wr({DEV_TYPE_CODE, 4'h6}, 1'b1);
    u_m.clk_bit(1'b1, a);
    u_m.clk_bit(1'b0, a);
    u_m.clk_bit(1'b1, a);
    u_m.start();
    wr({DEV_TYPE_CODE, 4'h6}, 1'b1);
    wr({OPC_RD_WIPER, 4'h1}, 1'b1);
    u_m.xfer(8'hff, 1'b1, q, a);
    chk("rd_wiper", 8'h3c, q);
    u_m.stop();
    chk("instr", {OPC_RD_WIPER, 4'h1}, got_i);
    $display("test restart done");
  endtask
  initial begin
    rst_n = 1'b0;
    strap = 4'ha;
    rd_val = 8'h00;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (100) @(posedge clk_sys);
    chk("restore", 8'h01, 8'(n_rs));
    t_write();
    t_miss();
    t_nv();
    t_read();
    t_restart();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end
endmodule
